// ---- sfm_top.sv ----
// Conversion result buffer: mode control, storage and readout stream
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - With bit 19 set, a read command sends the status word before the samples.
// - Status goes once per command even when every sample carries a header.
// - Bit 18 resets high; when set each sample gets a header before data.
// - Mode field resets to 00; then results bypass the buffer to data register.
// - Watermark mode keeps first N results, drops later ones until fully read.
// - Reading a sample removes it and frees its storage.
// - Watermark mode sets overrun when a newer result is dropped.
// - Modes 10 and 11 keep newest results, dropping oldest once depth is full.
// - Streaming mode sets overrun when an old sample is discarded.
// - Bit 10 lets overrun raise the interrupt; clear means no interrupt.
module sfm_top #(
  parameter int DEPTH = 256
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [23:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [23:0] reg_rdata,
  input wire logic conv_valid,
  input wire logic [15:0] conv_data,
  input wire logic [3:0] conv_chan,
  output logic out_valid,
  output logic [23:0] out_word,
  output logic [1:0] out_kind,
  input wire logic out_ready,
  output logic irq_overrun
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);

  logic rst_q1;
  logic rst_n_s;
  logic [23:0] ctrl;
  logic [AW:0] wmark;
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [AW:0] rem;
  logic ovr;
  logic wm_lock;
  logic [23:0] data_reg;
  logic data_rdy;
  logic [19:0] hold;
  sfm_pkg::sfm_state_t st;
  logic e1_valid;
  logic [23:0] e1_word;
  logic [1:0] e1_kind;

  sfm_mem_if #(.AW(AW), .DW(sfm_pkg::STORE_W)) mif();

  sfm_mem #(.DEPTH(DEPTH), .DW(sfm_pkg::STORE_W)) u_mem (
    .clk(clk),
    .port(mif)
  );

  // Reset release through two flops; assertion is immediate
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_q1 <= 1'b0;
      rst_n_s <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n_s <= rst_q1;
    end
  end

  // Decoded controls
  logic [1:0] mode;
  logic buf_on;
  logic stream_mode;
  logic ctrl_wr;
  logic flush;
  logic cmd_go;
  logic [AW:0] wm_eff;
  logic full;
  logic push_req;
  logic pop_rd;
  logic accept;
  logic drop_new;
  logic discard_old;
  logic [AW:0] next_count;
  logic sk_in_ready;
  logic sk_push;
  logic [23:0] sk_in_word;
  logic [1:0] sk_in_kind;
  logic [23:0] status_word;

  assign mode = ctrl[sfm_pkg::CTRL_MODE_HI:sfm_pkg::CTRL_MODE_LO];
  assign buf_on = (mode != sfm_pkg::MODE_OFF);
  assign stream_mode = mode[1];
  assign ctrl_wr = reg_wr && (reg_addr == sfm_pkg::ADDR_CTRL);
  // A mode change empties the store so old samples never leak into the new mode
  assign flush = ctrl_wr && (reg_wdata[sfm_pkg::CTRL_MODE_HI:sfm_pkg::CTRL_MODE_LO] != mode);
  assign cmd_go = reg_wr && (reg_addr == sfm_pkg::ADDR_CMD) && (st == sfm_pkg::S_IDLE);
  // Zero or oversized watermark falls back to the full depth
  assign wm_eff = ((wmark == '0) || (wmark > FULL_CNT)) ? FULL_CNT : wmark;
  assign full = (count == FULL_CNT);
  assign push_req = conv_valid && buf_on && !flush;
  assign pop_rd = (st == sfm_pkg::S_FETCH) && (count != '0) && (rem != '0) && buf_on;

  // Admission policy per mode
  always_comb begin
    accept = 1'b0;
    drop_new = 1'b0;
    discard_old = 1'b0;
    if (push_req && stream_mode) begin
      accept = 1'b1;
      discard_old = full && !pop_rd;
    end else if (push_req) begin
      accept = !wm_lock && !full;
      drop_new = wm_lock || full;
    end
  end

  assign next_count = count + (AW + 1)'(accept) - (AW + 1)'(pop_rd || discard_old);
  // Three flags, zero fill, then the fill level in the low bits: 24 bits in all
  assign status_word = {ovr, (count >= wm_eff), (count == '0), (20 - AW)'(0), count};

  // Memory port drive
  assign mif.wr_en = accept;
  assign mif.wr_addr = wr_ptr;
  assign mif.wr_data = {conv_chan, conv_data};
  assign mif.rd_en = pop_rd;
  assign mif.rd_addr = rd_ptr;

  // Pointers and fill level; each read removes the sample
  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else if (flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (accept) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop_rd || discard_old) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= next_count;
    end
  end

  // Watermark lock: set on reaching N, released once drained to empty
  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      wm_lock <= 1'b0;
    end else if (flush || mode != sfm_pkg::MODE_WMARK) begin
      wm_lock <= 1'b0;
    end else if (next_count >= wm_eff) begin
      wm_lock <= 1'b1;
    end else if (next_count == '0) begin
      wm_lock <= 1'b0;
    end
  end

  // Overrun flag: a new drop wins over a status read clearing it
  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      ovr <= 1'b0;
    end else if (drop_new || discard_old) begin
      ovr <= 1'b1;
    end else if (reg_rd && reg_addr == sfm_pkg::ADDR_STATUS) begin
      ovr <= 1'b0;
    end
  end

  // Interrupt only when enabled
  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      irq_overrun <= 1'b0;
    end else begin
      irq_overrun <= ovr && ctrl[sfm_pkg::CTRL_OVR_IE];
    end
  end

  // Bypass data register while the buffer is off
  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      data_reg <= '0;
      data_rdy <= 1'b0;
    end else if (conv_valid && !buf_on) begin
      data_reg <= {4'h0, conv_chan, conv_data};
      data_rdy <= 1'b1;
    end else if (reg_rd && reg_addr == sfm_pkg::ADDR_DATA) begin
      data_rdy <= 1'b0;
    end
  end

  // Control and watermark registers; reserved bits stay zero
  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      ctrl <= sfm_pkg::CTRL_RST;
      wmark <= (AW + 1)'(sfm_pkg::WMARK_RST);
    end else if (ctrl_wr) begin
      ctrl <= reg_wdata & sfm_pkg::CTRL_WMASK;
    end else if (reg_wr && reg_addr == sfm_pkg::ADDR_WMARK) begin
      wmark <= reg_wdata[AW:0];
    end
  end

  // Register read data, one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        sfm_pkg::ADDR_CTRL: reg_rdata <= ctrl;
        sfm_pkg::ADDR_WMARK: reg_rdata <= {(23 - AW)'(0), wmark};
        sfm_pkg::ADDR_STATUS: reg_rdata <= status_word;
        sfm_pkg::ADDR_DATA: reg_rdata <= {data_rdy, data_reg[22:0]};
        default: reg_rdata <= '0;
      endcase
    end
  end

  // Readout sequencer word source
  always_comb begin
    sk_push = 1'b0;
    sk_in_word = '0;
    sk_in_kind = sfm_pkg::KIND_DATA;
    case (st)
      sfm_pkg::S_STAT: begin
        sk_push = sk_in_ready;
        sk_in_word = status_word;
        sk_in_kind = sfm_pkg::KIND_STATUS;
      end
      sfm_pkg::S_HDR: begin
        sk_push = sk_in_ready;
        sk_in_word = {20'h00000, hold[19:16]};
        sk_in_kind = sfm_pkg::KIND_HEADER;
      end
      sfm_pkg::S_DATA: begin
        sk_push = sk_in_ready;
        sk_in_word = {8'h00, hold[15:0]};
        sk_in_kind = sfm_pkg::KIND_DATA;
      end
      default: begin
        sk_push = 1'b0;
      end
    endcase
  end

  // Readout sequencer; the sample count is fixed when the command lands
  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      st <= sfm_pkg::S_IDLE;
      rem <= '0;
      hold <= '0;
    end else begin
      case (st)
        sfm_pkg::S_IDLE: begin
          if (cmd_go) begin
            rem <= count;
            st <= ctrl[sfm_pkg::CTRL_ADD_STATUS] ? sfm_pkg::S_STAT : sfm_pkg::S_FETCH;
          end
        end
        sfm_pkg::S_STAT: begin
          if (sk_in_ready) begin
            st <= sfm_pkg::S_FETCH;
          end
        end
        sfm_pkg::S_FETCH: begin
          if (pop_rd) begin
            rem <= rem - 1'b1;
            st <= sfm_pkg::S_WAIT;
          end else begin
            st <= sfm_pkg::S_IDLE;
          end
        end
        sfm_pkg::S_WAIT: begin
          hold <= mif.rd_data;
          st <= ctrl[sfm_pkg::CTRL_ADD_HEADER] ? sfm_pkg::S_HDR : sfm_pkg::S_DATA;
        end
        sfm_pkg::S_HDR: begin
          if (sk_in_ready) begin
            st <= sfm_pkg::S_DATA;
          end
        end
        sfm_pkg::S_DATA: begin
          if (sk_in_ready) begin
            st <= sfm_pkg::S_FETCH;
          end
        end
        default: begin
          st <= sfm_pkg::S_IDLE;
        end
      endcase
    end
  end

  // Two-entry output buffer; a receiver stall parks one word in the spare slot
  assign sk_in_ready = !e1_valid;
  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      out_valid <= 1'b0;
      out_word <= '0;
      out_kind <= '0;
      e1_valid <= 1'b0;
      e1_word <= '0;
      e1_kind <= '0;
    end else if (e1_valid) begin
      if (out_ready) begin
        out_word <= e1_word;
        out_kind <= e1_kind;
        e1_valid <= 1'b0;
      end
    end else if (sk_push) begin
      if (!out_valid || out_ready) begin
        out_valid <= 1'b1;
        out_word <= sk_in_word;
        out_kind <= sk_in_kind;
      end else begin
        e1_valid <= 1'b1;
        e1_word <= sk_in_word;
        e1_kind <= sk_in_kind;
      end
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n_s);

  chk_status_first: assert property (cmd_go && ctrl[sfm_pkg::CTRL_ADD_STATUS] |=> st == sfm_pkg::S_STAT)
    else $error("status word not scheduled first");
  chk_status_once: assert property (sk_push && sk_in_kind == sfm_pkg::KIND_STATUS |=>
    st == sfm_pkg::S_FETCH ##1 st != sfm_pkg::S_STAT)
    else $error("status word repeated");
  chk_header_choice: assert property (st == sfm_pkg::S_WAIT |=>
    st == ($past(ctrl[sfm_pkg::CTRL_ADD_HEADER]) ? sfm_pkg::S_HDR : sfm_pkg::S_DATA))
    else $error("header insertion wrong");
  chk_off_bypass: assert property (conv_valid && mode == sfm_pkg::MODE_OFF |-> !mif.wr_en ##1 data_rdy)
    else $error("disabled mode stored sample");
  chk_wm_discard: assert property (conv_valid && mode == sfm_pkg::MODE_WMARK && wm_lock && !flush |-> !mif.wr_en)
    else $error("locked watermark buffer stored sample");
  chk_pop_frees: assert property (pop_rd && !accept && !flush |=> count == $past(count) - 1'b1)
    else $error("read did not free storage");
  chk_wm_overrun: assert property (drop_new |=> ovr)
    else $error("dropped new sample without overrun");
  chk_stream_keep: assert property (conv_valid && stream_mode && full && !pop_rd && !flush |->
    mif.wr_en ##1 full)
    else $error("streaming did not keep newest");
  chk_stream_overrun: assert property (discard_old |=> ovr && rd_ptr == $past(rd_ptr) + 1'b1)
    else $error("discard without overrun");
  chk_overrun_irq: assert property (##1 irq_overrun == $past(ovr && ctrl[sfm_pkg::CTRL_OVR_IE]))
    else $error("overrun interrupt mismatch");
  chk_depth_bound: assert property (count <= FULL_CNT)
    else $error("fill level beyond depth");

  cov_status_sent: cover property (sk_push && sk_in_kind == sfm_pkg::KIND_STATUS);
  cov_old_discard: cover property (discard_old);
  cov_new_drop: cover property (drop_new);
  cov_stall_park: cover property (e1_valid && !out_ready);
endmodule // sfm_top
`default_nettype wire

// ---- sfm_pkg.sv ----
// Shared constants and types for the sample buffer block
package sfm_pkg;
  // Register offsets on the plain register port
  localparam logic [7:0] ADDR_DATA = 8'h02;
  localparam logic [7:0] ADDR_CTRL = 8'h3a;
  localparam logic [7:0] ADDR_WMARK = 8'h3b;
  localparam logic [7:0] ADDR_STATUS = 8'h3c;
  localparam logic [7:0] ADDR_CMD = 8'h3d;
  // Control register layout and reset
  localparam logic [23:0] CTRL_RST = 24'h040200;
  localparam logic [23:0] CTRL_WMASK = 24'h0fffff;
  localparam int CTRL_ADD_STATUS = 19;
  localparam int CTRL_ADD_HEADER = 18;
  localparam int CTRL_MODE_HI = 17;
  localparam int CTRL_MODE_LO = 16;
  localparam int CTRL_OVR_IE = 10;
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_WMARK = 2'h1;
  // Watermark reset value
  localparam logic [8:0] WMARK_RST = 9'h010;
  // Status word layout
  localparam int STAT_OVR = 23;
  localparam int STAT_WM = 22;
  localparam int STAT_EMPTY = 21;
  // Widths
  localparam int WORD_W = 24;
  localparam int SAMPLE_W = 16;
  localparam int CHAN_W = 4;
  localparam int STORE_W = 20;
  // Kind of each word on the readout stream
  typedef enum logic [1:0] {
    KIND_STATUS = 2'h0,
    KIND_HEADER = 2'h1,
    KIND_DATA = 2'h2
  } sfm_kind_t;
  // Readout sequencer states
  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_STAT = 6'h02,
    S_FETCH = 6'h04,
    S_WAIT = 6'h08,
    S_HDR = 6'h10,
    S_DATA = 6'h20
  } sfm_state_t;
endpackage

// ---- sfm_mem_if.sv ----
// Port bundle between the buffer control and its sample memory
`timescale 1ns/1ps
`default_nettype none
interface sfm_mem_if #(parameter int AW = 8, parameter int DW = 20);
  logic wr_en;
  logic [AW-1:0] wr_addr;
  logic [DW-1:0] wr_data;
  logic rd_en;
  logic [AW-1:0] rd_addr;
  logic [DW-1:0] rd_data;
  modport ctl(output wr_en, output wr_addr, output wr_data, output rd_en, output rd_addr, input rd_data);
  modport mem(input wr_en, input wr_addr, input wr_data, input rd_en, input rd_addr, output rd_data);
endinterface
`default_nettype wire

// ---- sfm_mem.sv ----
// Sample store with registered read data
`timescale 1ns/1ps
`default_nettype none
module sfm_mem #(
  parameter int DEPTH = 256,
  parameter int DW = 20
) (
  input wire logic clk,
  sfm_mem_if.mem port
);
  logic [DW-1:0] store [DEPTH];

  // Write port
  always_ff @(posedge clk) begin
    if (port.wr_en) begin
      store[port.wr_addr] <= port.wr_data;
    end
  end

  // Read data from a register, one cycle after the request
  always_ff @(posedge clk) begin
    if (port.rd_en) begin
      port.rd_data <= store[port.rd_addr];
    end
  end
endmodule // sfm_mem
`default_nettype wire

// ---- sfm_host_model.sv ----
// Host side model: drains the readout stream and records each word taken
`timescale 1ns/1ps
`default_nettype none
module sfm_host_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic stall,
  input wire logic out_valid,
  input wire logic [23:0] out_word,
  input wire logic [1:0] out_kind,
  output logic out_ready
);
  logic [23:0] words[$];
  logic [1:0] kinds[$];
  // Stalling host accepts every other cycle, so the buffer must hold words
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) out_ready <= 1'b0;
    else out_ready <= stall ? ~out_ready : 1'b1;
  end
  // Record each word the moment it is handed over
  always @(posedge clk) begin
    if (out_valid && out_ready) begin
      words.push_back(out_word);
      kinds.push_back(out_kind);
    end
  end
endmodule // sfm_host_model
`default_nettype wire

// ---- test_sample_fifo_mode_and_readout.sv ----
// Self-checking bench for the sample buffer with a draining host model
`timescale 1ns/1ps
`default_nettype none
module test_sample_fifo_mode_and_readout;
  logic clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, conv_valid = 1'b0, stall = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [23:0] reg_wdata = 24'h000000, reg_rdata, out_word, d;
  logic [15:0] conv_data = 16'h0000;
  logic [3:0] conv_chan = 4'h0;
  logic out_valid, out_ready, irq_overrun;
  logic [1:0] out_kind;
  int failures = 0, tests_run = 0;
  // Short depth keeps the streaming discard point reachable
  sfm_top #(.DEPTH(8)) dut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_valid(conv_valid),
    .conv_data(conv_data), .conv_chan(conv_chan), .out_valid(out_valid), .out_word(out_word),
    .out_kind(out_kind), .out_ready(out_ready), .irq_overrun(irq_overrun));
  sfm_host_model host (.clk(clk), .rstn(rstn), .stall(stall), .out_valid(out_valid),
    .out_word(out_word), .out_kind(out_kind), .out_ready(out_ready));
  always #4 clk = ~clk;
  task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [23:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // Read data appear in the cycle after the strobe and hold until the next read
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // Back-to-back results; channel follows the index
  task automatic push(input int n, input logic [15:0] base);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      conv_valid <= 1'b1;
      conv_data <= base + 16'(i);
      conv_chan <= 4'(i + 1);
    end
    @(posedge clk);
    conv_valid <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic rd_stat(input logic [23:0] exp);
    rd(sfm_pkg::ADDR_STATUS);
    chk("status", exp, d & 24'he001ff);
  endtask
  // Start a readout and wait, bounded, for the expected number of words
  task automatic readout(input int n);
    int k;
    host.words.delete();
    host.kinds.delete();
    wr(sfm_pkg::ADDR_CMD, 24'h000001);
    for (k = 0; k < 400 && host.words.size() < n; k++) @(posedge clk);
    repeat (20) @(posedge clk);
    chk("word count", 24'(n), 24'(host.words.size()));
  endtask
  task automatic chk_word(input int i, input logic [1:0] kind, input logic [23:0] v, input logic [23:0] m);
    if (i < host.words.size()) begin
      chk("kind", 24'(kind), 24'(host.kinds[i]));
      chk("word", v, host.words[i] & m);
    end
  endtask
  task automatic t_reset;
    rd(sfm_pkg::ADDR_CTRL);
    chk("ctrl reset", 24'h040200, d);
    rd(8'h10);
    chk("unmapped", 24'h000000, d);
    rd_stat(24'h200000);
  endtask
  task automatic t_bypass;
    push(1, 16'h0abc);
    rd(sfm_pkg::ADDR_DATA);
    chk("data reg", 24'h810abc, d);
    rd_stat(24'h200000);
  endtask
  task automatic t_watermark;
    wr(sfm_pkg::ADDR_WMARK, 24'h000004);
    wr(sfm_pkg::ADDR_CTRL, 24'h0d0600);
    push(6, 16'h1000);
    chk("irq on", 24'h1, 24'(irq_overrun));
    rd_stat(24'hc00004);
    rd_stat(24'h400004);
    chk("irq off", 24'h0, 24'(irq_overrun));
    readout(9);
    chk_word(0, sfm_pkg::KIND_STATUS, 24'h400004, 24'he001ff);
    for (int i = 0; i < 4; i++) begin
      chk_word(1 + 2 * i, sfm_pkg::KIND_HEADER, 24'(i + 1), 24'h00000f);
      chk_word(2 + 2 * i, sfm_pkg::KIND_DATA, 24'h001000 + 24'(i), 24'h00ffff);
    end
    rd_stat(24'h200000);
    push(1, 16'h2000);
    rd_stat(24'h000001);
  endtask
  // Both streaming encodings, headers off, host stalling during readout
  task automatic t_stream(input logic [1:0] mode);
    wr(sfm_pkg::ADDR_CTRL, {6'h00, mode, 16'h0000});
    push(10, 16'h3000);
    rd_stat(24'hc00008);
    chk("irq masked", 24'h0, 24'(irq_overrun));
    stall <= 1'b1;
    readout(8);
    stall <= 1'b0;
    for (int i = 0; i < 8; i++) chk_word(i, sfm_pkg::KIND_DATA, 24'h003002 + 24'(i), 24'h00ffff);
    rd_stat(24'h200000);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    end_of_test;
  end
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset;
    t_bypass;
    t_watermark;
    t_stream(2'h2);
    t_stream(2'h3);
    end_of_test;
  end
endmodule // test_sample_fifo_mode_and_readout
`default_nettype wire
